// *** rtl/tecu_edge.sv ***
// Synchroniser and edge detector for the capture source
`timescale 1ns/1ps
`default_nettype none
module tecu_edge (
    // Clock, reset and enable
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic en_i,
    // Source and edges
    tecu_if.det e
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic rise;
        logic fall;
    } tecu_edge_st_t;
    tecu_edge_st_t st_q;
    tecu_edge_st_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = e.src;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        st_d.rise = st_q.s2 & ~st_q.s3;
        st_d.fall = ~st_q.s2 & st_q.s3;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_q <= '0;
        end else if (en_i) begin
            st_q <= st_d;
        end
    end

    assign e.rise = st_q.rise;
    assign e.fall = st_q.fall;
endmodule
`default_nettype wire

// *** rtl/tecu_if.sv ***
// Interface carrying the selected source and edge pulses
`timescale 1ns/1ps
`default_nettype none
interface tecu_if;
    logic src;
    logic rise;
    logic fall;
    modport det (input src, output rise, output fall);
    modport core (output src, input rise, input fall);
endinterface
`default_nettype wire

// *** rtl/tecu_pkg.sv ***
// Package of constants for the timer event capture unit
package tecu_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SRC = 8'h04;
    localparam logic [7:0] ADDR_VALUE = 8'h08;
    localparam logic [7:0] ADDR_FLAG = 8'h0c;
    localparam logic [7:0] ADDR_MASK = 8'h10;
    localparam logic [7:0] ADDR_TIMER = 8'h14;
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_ANY = 4'h3;
    localparam logic [3:0] MODE_FALL = 4'h4;
    localparam logic [3:0] MODE_RISE = 4'h5;
    localparam logic [3:0] MODE_RISE4 = 4'h6;
    localparam logic [3:0] MODE_RISE16 = 4'h7;
    localparam logic [3:0] PRESC_4_LAST = 4'h3;
    localparam logic [3:0] PRESC_16_LAST = 4'hf;
    localparam int SRC_PIN = 0;
    localparam int SRC_CMP1 = 1;
    localparam int SRC_CMP2 = 2;
    localparam int SRC_CMP7 = 3;
    localparam int SRC_CMP8 = 4;
    localparam int SRC_LC2 = 5;
    localparam int SRC_LC3 = 6;
    localparam int SRC_IOC = 7;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [2:0] SRC_RESET = 3'h0;
    localparam logic MASK_RESET = 1'b0;
endpackage

// *** rtl/tecu_top.sv ***
// Timer event capture unit with APB registers and interrupt
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - All capture instances behave identically; only names differ.
// - Qualifying event copies 16-bit timer count into capture value.
// - Mode selects any edge, falling, rising, 4th or 16th rising.
// - Source select picks pin, comparators, logic cells, or pin-change trigger.
// - Each capture sets the capture interrupt flag.
// - New captures overwrite the stored value, no overrun protection.
// - Pin latch writes changing an output pin also count as events.
// - Capture value held as low and high bytes, not reset.
module tecu_top (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic clk_en_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Timer and event sources
    input wire logic [15:0] timer_count_i,
    input wire logic pin_i,
    input wire logic pin_direction_ctl_i,
    input wire logic pin_latch_i,
    input wire logic comparator1_synced_out_i,
    input wire logic comparator2_synced_out_i,
    input wire logic comparator7_synced_out_i,
    input wire logic comparator8_synced_out_i,
    input wire logic logic_cell2_out_i,
    input wire logic logic_cell3_out_i,
    input wire logic pin_change_trigger_i,
    // Results
    output logic capture_irq_flag_o,
    output logic irq_o,
    output logic [7:0] capture_value_low_o,
    output logic [7:0] capture_value_high_o
);
    typedef struct packed {
        logic [3:0] mode;
        logic [2:0] src_sel;
        logic mask;
        logic flag;
        logic [3:0] presc;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } tecu_st_t;
    tecu_st_t st_q;
    tecu_st_t st_d;
    // Capture value kept apart: it has no reset, the rest has an async one
    logic [7:0] val_lo_q;
    logic [7:0] val_lo_d;
    logic [7:0] val_hi_q;
    logic [7:0] val_hi_d;

    tecu_if ev ();

    logic [7:0] srcs;
    logic capture;
    logic qual;
    logic setup;
    logic wr;
    logic rd;
    logic hit;

    // Output pin level follows the latch when driven, so latch writes look like edges
    // latch drives pin
    assign srcs[tecu_pkg::SRC_PIN] = pin_direction_ctl_i ? pin_i : pin_latch_i;
    assign srcs[tecu_pkg::SRC_CMP1] = comparator1_synced_out_i;
    assign srcs[tecu_pkg::SRC_CMP2] = comparator2_synced_out_i;
    assign srcs[tecu_pkg::SRC_CMP7] = comparator7_synced_out_i;
    assign srcs[tecu_pkg::SRC_CMP8] = comparator8_synced_out_i;
    assign srcs[tecu_pkg::SRC_LC2] = logic_cell2_out_i;
    assign srcs[tecu_pkg::SRC_LC3] = logic_cell3_out_i;
    assign srcs[tecu_pkg::SRC_IOC] = pin_change_trigger_i;
    assign ev.src = srcs[st_q.src_sel];

    tecu_edge u_edge (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .en_i(clk_en_i),
        .e(ev)
    );

    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] r);
        addr_is = (a == r);
    endfunction

    assign setup = psel_i & ~penable_i;
    assign wr = setup & pwrite_i;
    assign rd = setup & ~pwrite_i;
    assign hit = addr_is(paddr_i, tecu_pkg::ADDR_CTRL) | addr_is(paddr_i, tecu_pkg::ADDR_SRC)
               | addr_is(paddr_i, tecu_pkg::ADDR_VALUE) | addr_is(paddr_i, tecu_pkg::ADDR_FLAG)
               | addr_is(paddr_i, tecu_pkg::ADDR_MASK) | addr_is(paddr_i, tecu_pkg::ADDR_TIMER);

    always_comb begin
        qual = 1'b0;
        unique case (st_q.mode)
            tecu_pkg::MODE_ANY: qual = ev.rise | ev.fall;
            tecu_pkg::MODE_FALL: qual = ev.fall;
            tecu_pkg::MODE_RISE: qual = ev.rise;
            tecu_pkg::MODE_RISE4: qual = ev.rise && st_q.presc == tecu_pkg::PRESC_4_LAST;
            tecu_pkg::MODE_RISE16: qual = ev.rise && st_q.presc == tecu_pkg::PRESC_16_LAST;
            default: qual = 1'b0;
        endcase
    end
    assign capture = qual;

    always_comb begin
        st_d = st_q;
        val_lo_d = val_lo_q;
        val_hi_d = val_hi_q;
        st_d.pready = setup;
        st_d.pslverr = setup & ~hit;
        st_d.prdata = '0;
        if (ev.rise && (st_q.mode == tecu_pkg::MODE_RISE4 || st_q.mode == tecu_pkg::MODE_RISE16)) begin
            st_d.presc = capture ? 4'h0 : st_q.presc + 4'h1;
        end
        if (capture) begin
            val_lo_d = timer_count_i[7:0];
            val_hi_d = timer_count_i[15:8];
        end
        if (rd) begin
            if (addr_is(paddr_i, tecu_pkg::ADDR_CTRL)) begin
                st_d.prdata = {28'h000_0000, st_q.mode};
            end else if (addr_is(paddr_i, tecu_pkg::ADDR_SRC)) begin
                st_d.prdata = {29'h000_0000, st_q.src_sel};
            end else if (addr_is(paddr_i, tecu_pkg::ADDR_VALUE)) begin
                st_d.prdata = {16'h0000, val_hi_q, val_lo_q};
            end else if (addr_is(paddr_i, tecu_pkg::ADDR_FLAG)) begin
                st_d.prdata = {31'h0000_0000, st_q.flag};
            end else if (addr_is(paddr_i, tecu_pkg::ADDR_MASK)) begin
                st_d.prdata = {31'h0000_0000, st_q.mask};
            end else if (addr_is(paddr_i, tecu_pkg::ADDR_TIMER)) begin
                st_d.prdata = {16'h0000, timer_count_i};
            end
        end
        if (wr) begin
            if (addr_is(paddr_i, tecu_pkg::ADDR_CTRL)) begin
                st_d.mode = pwdata_i[3:0];
                if (pwdata_i[3:0] != st_q.mode) begin
                    st_d.presc = 4'h0;
                end
            end
            if (addr_is(paddr_i, tecu_pkg::ADDR_SRC)) begin
                st_d.src_sel = pwdata_i[2:0];
            end
            if (addr_is(paddr_i, tecu_pkg::ADDR_MASK)) begin
                st_d.mask = pwdata_i[0];
            end
        end
        // flag clears only by software read or by async reset
        if (rd && addr_is(paddr_i, tecu_pkg::ADDR_FLAG)) begin
            st_d.flag = 1'b0;
        end
        if (capture) begin
            st_d.flag = 1'b1;
        end
        st_d.irq = st_d.flag & st_d.mask;
    end

    // Capture value is not reset, so it keeps content across resets
    always_ff @(posedge clk_i) begin
        if (clk_en_i) begin
            val_lo_q <= val_lo_d;
            val_hi_q <= val_hi_d;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_q.mode <= tecu_pkg::CTRL_RESET;
            st_q.src_sel <= tecu_pkg::SRC_RESET;
            st_q.mask <= tecu_pkg::MASK_RESET;
            st_q.flag <= 1'b0;
            st_q.presc <= 4'h0;
            st_q.prdata <= '0;
            st_q.pready <= 1'b0;
            st_q.pslverr <= 1'b0;
            st_q.irq <= 1'b0;
        end else if (clk_en_i) begin
            st_q.mode <= st_d.mode;
            st_q.src_sel <= st_d.src_sel;
            st_q.mask <= st_d.mask;
            st_q.flag <= st_d.flag;
            st_q.presc <= st_d.presc;
            st_q.prdata <= st_d.prdata;
            st_q.pready <= st_d.pready;
            st_q.pslverr <= st_d.pslverr;
            st_q.irq <= st_d.irq;
        end
    end

    assign prdata_o = st_q.prdata;
    assign pready_o = st_q.pready;
    assign pslverr_o = st_q.pslverr;
    assign capture_irq_flag_o = st_q.flag;
    assign irq_o = st_q.irq;
    assign capture_value_low_o = val_lo_q;
    assign capture_value_high_o = val_hi_q;

    // Capture and flag
    capture_loads_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (capture && clk_en_i) |=> ({capture_value_high_o, capture_value_low_o} == $past(timer_count_i)))
        else $error("capture value not loaded");
    capture_flags_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (capture && clk_en_i) |=> capture_irq_flag_o)
        else $error("flag not set by capture");
    flag_sticky_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (capture_irq_flag_o && !(rd && addr_is(paddr_i, tecu_pkg::ADDR_FLAG))) |=> capture_irq_flag_o)
        else $error("flag cleared without read");
    rise_mode_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (st_q.mode == tecu_pkg::MODE_RISE && ev.fall) |-> !capture)
        else $error("falling edge captured in rise mode");
    fall_mode_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (st_q.mode == tecu_pkg::MODE_FALL && ev.rise) |-> !capture)
        else $error("rising edge captured in fall mode");
    presc_clear_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (wr && clk_en_i && addr_is(paddr_i, tecu_pkg::ADDR_CTRL) && pwdata_i[3:0] != st_q.mode)
        |=> st_q.presc == 4'h0)
        else $error("prescaler not cleared on mode change");
    irq_gate_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        irq_o == (capture_irq_flag_o & st_q.mask))
        else $error("interrupt not gated by mask");
    apb_ready_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (setup && clk_en_i) |=> pready_o)
        else $error("pready not one cycle after setup");
    edge_latency_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (clk_en_i && ev.src && !$past(ev.src)) ##1 clk_en_i ##1 clk_en_i |=> ev.rise)
        else $error("edge not detected");

    // Qualification per mode
    off_mode_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (st_q.mode == tecu_pkg::MODE_OFF) |-> !capture)
        else $error("capture while mode is off");
    any_mode_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (st_q.mode == tecu_pkg::MODE_ANY && (ev.rise || ev.fall)) |-> capture)
        else $error("edge missed in any-edge mode");
    rise_fire_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (st_q.mode == tecu_pkg::MODE_RISE && ev.rise) |-> capture)
        else $error("rising edge missed");
    fall_fire_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (st_q.mode == tecu_pkg::MODE_FALL && ev.fall) |-> capture)
        else $error("falling edge missed");
    rise4_gate_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (st_q.mode == tecu_pkg::MODE_RISE4 && ev.rise && st_q.presc != tecu_pkg::PRESC_4_LAST) |-> !capture)
        else $error("early capture in fourth-edge mode");
    rise16_fire_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (st_q.mode == tecu_pkg::MODE_RISE16 && ev.rise && st_q.presc == tecu_pkg::PRESC_16_LAST) |-> capture)
        else $error("sixteenth edge missed");
    presc_step_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (clk_en_i && !setup && ev.rise && st_q.mode == tecu_pkg::MODE_RISE4 && !capture)
        |=> st_q.presc == $past(st_q.presc) + 4'h1)
        else $error("prescaler did not count");
    flag_clear_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (clk_en_i && rd && addr_is(paddr_i, tecu_pkg::ADDR_FLAG) && !capture) |=> !capture_irq_flag_o)
        else $error("flag not cleared by read");
    pin_latch_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (st_q.src_sel == 3'(tecu_pkg::SRC_PIN) && !pin_direction_ctl_i) |-> ev.src == pin_latch_i)
        else $error("latch not seen as pin level");
    edge_excl_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !(ev.rise && ev.fall))
        else $error("rise and fall together");

    // Bus and enable
    freeze_state_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !clk_en_i
        |=> ($stable(st_q) && $stable({val_hi_q, val_lo_q})))
        else $error("state moved while disabled");
    slverr_map_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (clk_en_i && setup && !hit) |=> pslverr_o)
        else $error("no error for unmapped address");
    ready_pulse_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (clk_en_i && pready_o) |=> !pready_o)
        else $error("pready held too long");
    rdata_idle_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !pready_o |-> (prdata_o == 32'h0000_0000))
        else $error("read data outside access");
    mask_write_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (clk_en_i && wr && addr_is(paddr_i, tecu_pkg::ADDR_MASK)) |=> (st_q.mask == $past(pwdata_i[0])))
        else $error("mask write lost");
endmodule
`default_nettype wire

// *** sim/tecu_src_model.sv ***
// Behavioural event sources seen by the capture unit
`timescale 1ns/1ps
`default_nettype none
module tecu_src_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Requested levels, bit index is the source code
    input wire logic [7:0] lvl_i,
    // Source levels
    output logic [7:0] src_o
);
    // Sources move just after an edge, like real logic outputs
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            src_o <= 8'h00;
        end else begin
            src_o <= lvl_i;
        end
    end
endmodule
`default_nettype wire

// *** sim/timer_event_capture_unit_bench.sv ***
// Self-checking bench for the timer event capture unit
`timescale 1ns/1ps
`default_nettype none
module timer_event_capture_unit_bench;
    typedef struct {int s; logic [3:0] m; logic [7:0] k; int n; logic e;} tecu_row_t;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, dir = 1'b1, latch = 1'b0, en = 1'b1, err;
    logic [7:0] paddr = 8'h00, lvl = 8'h00, src, lo, hi;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic pready, pslverr, flag, irq;
    logic [15:0] timer = 16'ha5c0, rise_t, fall_t, keep;
    int errors = 0, samples_checked = 0;
    tecu_row_t rows [11] = '{
        '{tecu_pkg::SRC_PIN, tecu_pkg::MODE_ANY, 8'h01, 1, 1'b1},
        '{tecu_pkg::SRC_CMP1, tecu_pkg::MODE_FALL, 8'h02, 1, 1'b1},
        '{tecu_pkg::SRC_CMP2, tecu_pkg::MODE_RISE, 8'h04, 1, 1'b1},
        '{tecu_pkg::SRC_CMP7, tecu_pkg::MODE_RISE4, 8'h08, 3, 1'b0},
        '{tecu_pkg::SRC_CMP7, tecu_pkg::MODE_RISE4, 8'h08, 1, 1'b1},
        '{tecu_pkg::SRC_CMP8, tecu_pkg::MODE_RISE16, 8'h10, 16, 1'b1},
        '{tecu_pkg::SRC_LC2, tecu_pkg::MODE_OFF, 8'h20, 1, 1'b0},
        '{tecu_pkg::SRC_LC3, tecu_pkg::MODE_RISE16, 8'h40, 15, 1'b0},
        '{tecu_pkg::SRC_LC3, tecu_pkg::MODE_RISE16, 8'h40, 1, 1'b1},
        '{tecu_pkg::SRC_LC3, tecu_pkg::MODE_RISE, 8'hbf, 1, 1'b0},
        '{tecu_pkg::SRC_IOC, tecu_pkg::MODE_RISE, 8'h80, 1, 1'b1}};
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    tecu_src_model i_tecu_src_model (.clk_i(clk_i), .arst_n_i(arst_n_i), .lvl_i(lvl), .src_o(src));
    tecu_top i_tecu_top (.clk_i(clk_i), .arst_n_i(arst_n_i), .clk_en_i(en), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .timer_count_i(timer), .pin_i(src[0]),
        .pin_direction_ctl_i(dir), .pin_latch_i(latch), .comparator1_synced_out_i(src[1]),
        .comparator2_synced_out_i(src[2]), .comparator7_synced_out_i(src[3]),
        .comparator8_synced_out_i(src[4]), .logic_cell2_out_i(src[5]), .logic_cell3_out_i(src[6]),
        .pin_change_trigger_i(src[7]), .capture_irq_flag_o(flag), .irq_o(irq),
        .capture_value_low_o(lo), .capture_value_high_o(hi));
    task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        // Only the watchdog ends a stuck wait
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rchk(input string s, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        check(s, q, e);
    endtask
    // Latch follows the pulse only while the pin is an output
    task automatic pulse(input logic [7:0] k, input int n);
        repeat (n) begin
            rise_t = timer + 16'h0001;
            timer <= rise_t;
            lvl <= k;
            latch <= ~dir;
            repeat (8) @(posedge clk_i);
            fall_t = timer + 16'h0001;
            timer <= fall_t;
            lvl <= 8'h00;
            latch <= 1'b0;
            repeat (8) @(posedge clk_i);
        end
    endtask
    task automatic setup(input logic [3:0] m, input int s);
        apb(1'b1, tecu_pkg::ADDR_CTRL, {28'h000_0000, m});
        apb(1'b1, tecu_pkg::ADDR_SRC, {29'h0000_0000, 3'(s)});
        apb(1'b0, tecu_pkg::ADDR_FLAG, 32'h0000_0000);
    endtask
    task automatic complete_run();
        $display("Checked %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        // About nine times the expected length of all tests
        #(10000 * 5);
        errors++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        rchk("ctrl", tecu_pkg::ADDR_CTRL, {28'h000_0000, tecu_pkg::CTRL_RESET});
        rchk("src", tecu_pkg::ADDR_SRC, {29'h0000_0000, tecu_pkg::SRC_RESET});
        rchk("mask", tecu_pkg::ADDR_MASK, {31'h0000_0000, tecu_pkg::MASK_RESET});
        rchk("timer", tecu_pkg::ADDR_TIMER, {16'h0000, timer});
        rchk("unmapped", 8'h18, 32'h0000_0000);
        check("slverr", {31'h0000_0000, err}, 32'h0000_0001);
        $display("Test reset done");
        foreach (rows[i]) begin
            setup(rows[i].m, rows[i].s);
            pulse(rows[i].k, rows[i].n);
            check("flag", {31'h0000_0000, flag}, {31'h0000_0000, rows[i].e});
            keep = (rows[i].m == tecu_pkg::MODE_FALL || rows[i].m == tecu_pkg::MODE_ANY) ? fall_t : rise_t;
            if (rows[i].e) rchk("value", tecu_pkg::ADDR_VALUE, {16'h0000, keep});
            $display("Test row %0d done", i);
        end
        setup(tecu_pkg::MODE_RISE, tecu_pkg::SRC_LC2);
        pulse(8'h20, 1);
        check("irq masked", {31'h0000_0000, irq}, 32'h0000_0000);
        apb(1'b1, tecu_pkg::ADDR_MASK, 32'h0000_0001);
        rchk("value", tecu_pkg::ADDR_VALUE, {16'h0000, rise_t});
        check("flag after value read", {31'h0000_0000, flag}, 32'h0000_0001);
        pulse(8'h20, 1);
        check("flag kept", {31'h0000_0000, flag}, 32'h0000_0001);
        check("irq", {31'h0000_0000, irq}, 32'h0000_0001);
        rchk("overwrite", tecu_pkg::ADDR_VALUE, {16'h0000, rise_t});
        rchk("flag read", tecu_pkg::ADDR_FLAG, 32'h0000_0001);
        check("irq cleared", {31'h0000_0000, irq}, 32'h0000_0000);
        $display("Test overwrite done");
        setup(tecu_pkg::MODE_RISE4, tecu_pkg::SRC_CMP1);
        pulse(8'h02, 3);
        apb(1'b1, tecu_pkg::ADDR_CTRL, {28'h000_0000, tecu_pkg::MODE_RISE16});
        apb(1'b1, tecu_pkg::ADDR_CTRL, {28'h000_0000, tecu_pkg::MODE_RISE4});
        pulse(8'h02, 1);
        check("presc cleared", {31'h0000_0000, flag}, 32'h0000_0000);
        pulse(8'h02, 3);
        check("presc fourth", {31'h0000_0000, flag}, 32'h0000_0001);
        $display("Test prescaler done");
        setup(tecu_pkg::MODE_RISE, tecu_pkg::SRC_PIN);
        dir <= 1'b0;
        @(posedge clk_i);
        pulse(8'h00, 1);
        check("latch flag", {31'h0000_0000, flag}, 32'h0000_0001);
        rchk("latch value", tecu_pkg::ADDR_VALUE, {16'h0000, rise_t});
        dir <= 1'b1;
        $display("Test latch done");
        setup(tecu_pkg::MODE_RISE, tecu_pkg::SRC_CMP2);
        en <= 1'b0;
        pulse(8'h04, 1);
        en <= 1'b1;
        repeat (4) @(posedge clk_i);
        check("frozen flag", {31'h0000_0000, flag}, 32'h0000_0000);
        pulse(8'h04, 1);
        check("enabled flag", {31'h0000_0000, flag}, 32'h0000_0001);
        $display("Test enable done");
        arst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        check("kept value", {16'h0000, hi, lo}, {16'h0000, rise_t});
        check("flag reset", {31'h0000_0000, flag}, 32'h0000_0000);
        $display("Test second reset done");
        complete_run();
    end
endmodule
`default_nettype wire
